// file: rtl/tlic_top.sv
// tlic_top: top-level and external interrupt arbitration with register file.
// assumes synchronous pins; the core reports write completion, instruction ends, returns, ei/di and wait mode.
`timescale 1ns/1ns
`default_nettype none
module tlic_top
    import tlic_pkg::*;
#(
    parameter int NUM_CH = NCH
)
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire tlic_bus_t bus_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire logic nonmask_pin_in,
    input wire logic watchdog_eoc_in,
    input wire logic [NUM_CH-1:0] ext_pin_in,
    input wire logic stack_in_regfile_in,
    input wire logic segment_push_enable_in,
    input wire logic core_waiting_in,
    input wire logic write_done_in,
    input wire logic instr_end_in,
    input wire logic iret_in,
    input wire logic ei_in,
    input wire logic di_in,
    output tlic_ack_t ack_out,
    output logic abort_out,
    output logic routine_start_out,
    output logic top_busy_out,
    output logic dma_block_out
);
    logic [7:0] central;
    logic [7:0] edge_sel;
    logic [7:0] pend;
    logic [7:0] unmask;
    logic [7:0] prio_pairs;
    logic [6:0] vec_base;
    logic [3:0] topcfg;
    logic lock;
    logic nmi_q;
    logic wdg_q;
    logic [NUM_CH-1:0] ext_q;
    logic top_event;
    logic [NUM_CH-1:0] ext_event;
    logic [NUM_CH-1:0] ext_req;
    logic top_req;
    logic [2:0] sample_cnt;
    logic [2:0] resolve_cnt;
    logic [4:0] cycle_cnt;
    logic [4:0] cycle_len;
    tlic_state_t state;
    logic win_valid;
    logic win_top;
    logic [2:0] win_ch;
    logic [2:0] win_prio;
    logic [2:0] held_prio;
    logic held_top;
    logic [2:0] held_ch;
    logic [2:0] saved_prio;
    logic wr_central;
    logic wr_pend;
    logic ack_fire;
    logic ret_fire;

    assign wr_central = bus_in.wr && (bus_in.addr == OFS_CENTRAL);
    assign wr_pend = bus_in.wr && (bus_in.addr == OFS_PEND);

    // edge detection; pins are assumed held one int clock before sampling
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            nmi_q <= 1'b0;
            wdg_q <= 1'b0;
            ext_q <= '0;
        end
        else
        begin
            nmi_q <= nonmask_pin_in;
            wdg_q <= watchdog_eoc_in;
            ext_q <= ext_pin_in;
        end
    end

    // top trigger: source and edge selection
    always_comb
    begin
        if (topcfg[B_TOPSRC])
            top_event = topcfg[B_TOPEDGE] ? (nonmask_pin_in && !nmi_q)
                                          : (!nonmask_pin_in && nmi_q);
        else
            top_event = watchdog_eoc_in && !wdg_q;
    end

    // per-channel edges; rising when edge bit set, channel 7 falling only
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (edge_sel[i] && (i != NUM_CH - 1))
                ext_event[i] = ext_pin_in[i] && !ext_q[i];
            else
                ext_event[i] = !ext_pin_in[i] && ext_q[i];
        end
    end

    // requests: channel needs unmask, pending and global allow
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
            ext_req[i] = unmask[i] && pend[i] && central[B_ALLOW];
        top_req = central[B_TOPPEND] &&
                  ((central[B_TOPMASK] && central[B_ALLOW]) || lock);
    end

    // priority of channel i: pair level from software, low bit fixed by parity
    function automatic logic [2:0] ch_prio(input logic [7:0] pairs, input int i);
        logic [1:0] p;
        p = pairs[(i/2)*2 +: 2];
        return {p, 1'(i % 2)};
    endfunction

    // winner search: top first, then lowest level strictly below running level
    always_comb
    begin
        win_valid = 1'b0;
        win_top = 1'b0;
        win_ch = '0;
        win_prio = PRIO_LOWEST;
        if (top_req)
        begin
            win_valid = 1'b1;
            win_top = 1'b1;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (ext_req[i] && ch_prio(prio_pairs, i) != PRIO_NEVER
                    && ch_prio(prio_pairs, i) < central[2:0]
                    && (!win_valid || ch_prio(prio_pairs, i) < win_prio))
                begin
                    win_valid = 1'b1;
                    win_ch = 3'(i);
                    win_prio = ch_prio(prio_pairs, i);
                end
            end
        end
    end

    // machine cycle length, plus one cycle from wait mode
    assign cycle_len = 5'(MACHINE_BASE)
        + (stack_in_regfile_in ? 5'(MACHINE_EXTRA) : 5'd0)
        + (segment_push_enable_in ? 5'(MACHINE_EXTRA) : 5'd0)
        + (core_waiting_in ? 5'(WAKE_EXTRA) : 5'd0);

    // free-running sampler independent of instruction flow
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            sample_cnt <= '0;
        else if (sample_cnt == 3'(SAMPLE_PERIOD - 1))
            sample_cnt <= '0;
        else
            sample_cnt <= sample_cnt + 3'd1;
    end

    // arbitration sequencer: sample, resolve, machine cycle, service
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= TLIC_IDLE;
            resolve_cnt <= '0;
            cycle_cnt <= '0;
            held_top <= 1'b0;
            held_ch <= '0;
            held_prio <= PRIO_LOWEST;
        end
        else
        begin
            unique case (state)
                TLIC_IDLE:
                begin
                    // top routine active blocks everything, including a second top
                    if (sample_cnt == '0 && win_valid && !top_busy_out)
                    begin
                        state <= TLIC_RESOLVE;
                        resolve_cnt <= 3'(RESOLVE_CYCLES - 1);
                        held_top <= win_top;
                        held_ch <= win_ch;
                        held_prio <= win_prio;
                    end
                end
                TLIC_RESOLVE:
                begin
                    if (resolve_cnt != '0)
                        resolve_cnt <= resolve_cnt - 3'd1;
                    else if (!write_done_in || instr_end_in)
                    begin
                        state <= TLIC_CYCLE;
                        cycle_cnt <= cycle_len - 5'd1;
                    end
                end
                TLIC_CYCLE:
                begin
                    if (cycle_cnt != '0)
                        cycle_cnt <= cycle_cnt - 5'd1;
                    else
                        state <= held_top ? TLIC_SERVICE : TLIC_IDLE;
                end
                TLIC_SERVICE:
                begin
                    if (iret_in)
                        state <= TLIC_IDLE;
                end
            endcase
        end
    end

    assign ack_fire = (state == TLIC_RESOLVE) && (resolve_cnt == '0)
                      && (!write_done_in || instr_end_in);
    assign ret_fire = iret_in && (state != TLIC_RESOLVE) && (state != TLIC_CYCLE);

    // acknowledge and abort indication toward the core
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_out <= '0;
            abort_out <= 1'b0;
            routine_start_out <= 1'b0;
        end
        else
        begin
            ack_out.valid <= ack_fire;
            ack_out.top <= held_top;
            ack_out.channel <= held_ch;
            ack_out.vector <= held_top ? TOP_VECTOR : {vec_base[6:3], held_ch};
            ack_out.priority_level <= held_prio;
            abort_out <= ack_fire && !write_done_in;
            routine_start_out <= (state == TLIC_CYCLE) && (cycle_cnt == '0);
        end
    end

    assign top_busy_out = (state == TLIC_SERVICE) ||
                          ((state != TLIC_IDLE) && held_top);
    assign dma_block_out = top_busy_out;

    // central register: pending, masks, allow, mode and running level
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            central <= RST_CENTRAL;
            saved_prio <= PRIO_LOWEST;
        end
        else
        begin
            if (wr_central)
                central <= bus_in.wdata;
            // hardware set wins over any write; software may also set it
            if (top_event)
                central[B_TOPPEND] <= 1'b1;
            else if (ack_fire && held_top)
                central[B_TOPPEND] <= 1'b0;
            else if (wr_central)
                central[B_TOPPEND] <= bus_in.wdata[B_TOPPEND] | central[B_TOPPEND];
            if (ack_fire && !held_top)
            begin
                central[B_ALLOW] <= 1'b0;
                if (central[B_ARB])
                begin
                    saved_prio <= central[2:0];
                    central[2:0] <= held_prio;
                end
            end
            else if (ret_fire && state != TLIC_SERVICE)
            begin
                central[B_ALLOW] <= 1'b1;
                if (central[B_ARB])
                    central[2:0] <= saved_prio;
            end
            else if (ei_in)
                central[B_ALLOW] <= 1'b1;
            else if (di_in)
                central[B_ALLOW] <= 1'b0;
        end
    end

    // channel pending: hardware set wins over software clear
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            pend <= RST_ZERO;
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (ext_event[i])
                    pend[i] <= 1'b1;
                else if (ack_fire && !held_top && held_ch == 3'(i))
                    pend[i] <= 1'b0;
                else if (wr_pend)
                    pend[i] <= bus_in.wdata[i];
            end
        end
    end

    // software configuration registers; lock is set-only and clears only on reset
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            edge_sel <= RST_ZERO;
            unmask <= RST_ZERO;
            prio_pairs <= RST_PRIO;
            vec_base <= '0;
            topcfg <= RST_TOPCFG;
            lock <= 1'b0;
        end
        else if (bus_in.wr)
        begin
            unique case (bus_in.addr)
                OFS_EDGE: edge_sel <= bus_in.wdata;
                OFS_CHMASK: unmask <= bus_in.wdata;
                OFS_CHPRIO: prio_pairs <= bus_in.wdata;
                OFS_CHVEC: vec_base <= bus_in.wdata[6:0];
                OFS_TOPCFG: topcfg <= bus_in.wdata[3:0];
                OFS_LOCK: lock <= lock | bus_in.wdata[B_LOCK];
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= '0;
        else if (bus_in.rd)
        begin
            unique case (bus_in.addr)
                OFS_CENTRAL: rdata_out <= central;
                OFS_EDGE: rdata_out <= edge_sel;
                OFS_PEND: rdata_out <= pend;
                OFS_CHMASK: rdata_out <= unmask;
                OFS_CHPRIO: rdata_out <= prio_pairs;
                OFS_CHVEC: rdata_out <= {1'b0, vec_base};
                OFS_TOPCFG: rdata_out <= {4'h0, topcfg};
                OFS_LOCK: rdata_out <= {lock, 7'h00};
                OFS_STATUS: rdata_out <= {top_busy_out, 5'h00, state};
                default: rdata_out <= '0;
            endcase
        end
        else
            rdata_out <= '0;
    end
endmodule
`default_nettype wire

// file: shared/tlic_pkg.sv
// tlic_pkg: constants and types for the top-level and external interrupt controller.
// assumes a plain register port with 8-bit registers at their printed offsets.
package tlic_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_CENTRAL = 8'h00_E6;
    localparam logic [7:0] OFS_EDGE = 8'h00_F2;
    localparam logic [7:0] OFS_PEND = 8'h00_F3;
    localparam logic [7:0] OFS_TOPCFG = 8'h00_F6;
    localparam logic [7:0] OFS_LOCK = 8'h00_F7;
    localparam logic [7:0] OFS_CHMASK = 8'h00_F4;
    localparam logic [7:0] OFS_CHPRIO = 8'h00_F5;
    localparam logic [7:0] OFS_CHVEC = 8'h00_F8;
    localparam logic [7:0] OFS_STATUS = 8'h00_F9;
    localparam logic [7:0] RST_CENTRAL = 8'h00_87;
    localparam logic [7:0] RST_ZERO = 8'h00_00;
    localparam logic [7:0] RST_PRIO = 8'h00_FF;
    localparam logic [3:0] RST_TOPCFG = 4'h0_6;
    // central register bit positions
    localparam int B_COUNTER = 7;
    localparam int B_TOPPEND = 6;
    localparam int B_TOPMASK = 5;
    localparam int B_ALLOW = 4;
    localparam int B_ARB = 3;
    // top configuration and lock register bit positions
    localparam int B_TOPEDGE = 3;
    localparam int B_TOPSRC = 2;
    localparam int B_LOCK = 7;
    localparam int NCH = 8;
    localparam logic [2:0] PRIO_NEVER = 3'h7;
    localparam logic [2:0] PRIO_LOWEST = 3'h7;
    // timing, in core clock cycles
    localparam int SAMPLE_PERIOD = 5;
    localparam int RESOLVE_CYCLES = 6;
    localparam int MACHINE_BASE = 18;
    localparam int MACHINE_EXTRA = 2;
    localparam int WAKE_EXTRA = 1;
    localparam int TOP_VEC_W = 7;
    localparam logic [6:0] TOP_VECTOR = 7'h7F;
    typedef enum logic [1:0]
    {
        TLIC_IDLE = 2'b00,
        TLIC_RESOLVE = 2'b01,
        TLIC_CYCLE = 2'b10,
        TLIC_SERVICE = 2'b11
    } tlic_state_t;
    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tlic_bus_t;
    typedef struct packed
    {
        logic valid;
        logic top;
        logic [2:0] channel;
        logic [6:0] vector;
        logic [2:0] priority_level;
    } tlic_ack_t;
endpackage

// file: sim/tlic_assertions.sv
// tlic_assertions: port-level checks of tlic_top.
// assumes binding to tlic_top; one clock, asynchronous high reset.
`timescale 1ns/1ns
`default_nettype none
module tlic_assertions
    import tlic_pkg::*;
#(
    parameter int NUM_CH = NCH
)
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire tlic_bus_t bus_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic write_done_in,
    input wire tlic_ack_t ack_out,
    input wire logic abort_out,
    input wire logic routine_start_out,
    input wire logic top_busy_out,
    input wire logic dma_block_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // a grant is followed by the machine cycle and then the routine start
    sequence s_grant;
        ack_out.valid;
    endsequence
    sequence s_start;
        ##[18:24] routine_start_out;
    endsequence
    a_start_after_grant: assert property (s_grant |-> s_start)
        else $error("routine start missing after grant");
    a_abort_cause: assert property (ack_out.valid |-> abort_out == !$past(write_done_in))
        else $error("abort does not follow write state");
    a_abort_alone: assert property (abort_out |-> ack_out.valid)
        else $error("abort without grant");
    a_grant_single: assert property (ack_out.valid |=> !ack_out.valid)
        else $error("grants too close");
    a_prio_never: assert property (ack_out.valid && !ack_out.top |-> ack_out.priority_level != PRIO_NEVER)
        else $error("level seven granted");
    a_top_vector: assert property (ack_out.valid && ack_out.top |-> ack_out.vector == TOP_VECTOR)
        else $error("top vector wrong");
    a_dma_blocked: assert property (ack_out.valid && ack_out.top |-> dma_block_out)
        else $error("dma not blocked in top routine");
    a_busy_no_grant: assert property (top_busy_out && $past(top_busy_out) |-> !ack_out.valid || ack_out.top)
        else $error("grant during top routine");
    a_read_idle: assert property (!$past(bus_in.rd) |-> rdata_out == '0)
        else $error("read data outside read slot");
endmodule
`default_nettype wire

// file: sim/tlic_core_model.sv
// tlic_core_model: cpu core stand-in ending instructions and returning from routines.
// assumes routine_start from tlic_top; iret comes hold_in plus one cycles after it.
`timescale 1ns/1ns
`default_nettype none
module tlic_core_model
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic routine_start_in,
    input wire logic [7:0] hold_in,
    output logic instr_end_out,
    output logic iret_out
);
    logic [7:0] svc_cnt;
    logic [1:0] ins_cnt;
    // four-cycle instructions, so a grant may have to wait for one to end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ins_cnt <= 2'h0;
            instr_end_out <= 1'b0;
        end
        else
        begin
            ins_cnt <= ins_cnt + 2'h1;
            instr_end_out <= (ins_cnt == 2'h3);
        end
    end
    // routine length from hold_in lets the bench answer promptly or slowly
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            svc_cnt <= 8'h00;
            iret_out <= 1'b0;
        end
        else
        begin
            iret_out <= (svc_cnt == 8'h01);
            if (routine_start_in)
                svc_cnt <= hold_in;
            else if (svc_cnt != 8'h00)
                svc_cnt <= svc_cnt - 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// tb_top: register-level tests of tlic_top with a core stand-in.
// assumes tlic_pkg offsets; pins held several cycles, well over one int clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import tlic_pkg::*;
;
    localparam int LIMIT = 20000;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    tlic_bus_t bus_in = '0;
    logic [7:0] rdata_out, v;
    logic [7:0] ext_pin = 8'h00;
    logic [7:0] hold = 8'h0C;
    logic nmi = 1'b1, wdog = 1'b0, stk = 1'b0, seg = 1'b0, wt = 1'b0;
    logic wdone = 1'b0, ei = 1'b0, di = 1'b0;
    logic instr_end, iret, abort, start, busy, dmab;
    tlic_ack_t ack, cap;
    logic ab_cap;
    int err_count = 0, cmp_count = 0, cyc = 0, d0, d1;
    tlic_top u_tlic_top (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in),
        .rdata_out(rdata_out), .nonmask_pin_in(nmi), .watchdog_eoc_in(wdog),
        .ext_pin_in(ext_pin), .stack_in_regfile_in(stk), .segment_push_enable_in(seg),
        .core_waiting_in(wt), .write_done_in(wdone), .instr_end_in(instr_end),
        .iret_in(iret), .ei_in(ei), .di_in(di), .ack_out(ack), .abort_out(abort),
        .routine_start_out(start), .top_busy_out(busy), .dma_block_out(dmab));
    tlic_core_model u_tlic_core_model (.clock_in(clock_in), .rst_in(rst_in),
        .routine_start_in(start), .hold_in(hold), .instr_end_out(instr_end),
        .iret_out(iret));
    // free-running clock and a cycle ceiling against hangs
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bus cycles: strobe for one cycle, read data in the following cycle only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus_in <= '0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock_in);
        bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        bus_in <= '0;
        #1;
        chk(rdata_out & m, e);
    endtask
    task automatic core_op(input logic e, input logic d);
        @(posedge clock_in);
        ei <= e;
        di <= d;
        @(posedge clock_in);
        ei <= 1'b0;
        di <= 1'b0;
    endtask
    task automatic pins(input logic [7:0] p);
        @(posedge clock_in);
        ext_pin <= p;
        repeat (4) @(posedge clock_in);
    endtask
    // wait a bounded time for a grant and keep it
    task automatic wack(input int n);
        cap = '0;
        ab_cap = 1'b0;
        for (int i = 0; i < n && cap.valid !== 1'b1; i++)
        begin
            @(posedge clock_in);
            #1;
            if (ack.valid === 1'b1)
            begin
                cap = ack;
                ab_cap = abort;
            end
        end
    endtask
    task automatic lat(output int d);
        d = 0;
        while (start !== 1'b1 && d < 60)
        begin
            @(posedge clock_in);
            #1;
            d++;
        end
    endtask
    // expect a top grant or none; a grant is followed by a fixed 40-cycle wait
    task automatic top_exp(input logic want);
        // a request raised during a top routine is granted only after its return
        wack(80);
        chk({cap.valid, cap.top, 6'h00}, {want, want, 6'h00});
        if (want)
            repeat (40) @(posedge clock_in);
    endtask
    initial
    begin
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        rc(OFS_CENTRAL, 8'hFF, RST_CENTRAL);
        rc(OFS_EDGE, 8'hFF, RST_ZERO);
        rc(OFS_PEND, 8'hFF, RST_ZERO);
        rc(OFS_TOPCFG, 8'h0F, {4'h0, RST_TOPCFG});
        rc(OFS_CHPRIO, 8'hFF, RST_PRIO);
        rc(8'h10, 8'hFF, 8'h00);
        wr(OFS_EDGE, 8'h7F);
        rc(OFS_EDGE, 8'hFF, 8'h7F);
        wr(OFS_CHMASK, 8'h01);
        wr(OFS_CHPRIO, 8'h00);
        core_op(1'b1, 1'b0);
        rc(OFS_CENTRAL, 8'h10, 8'h10);
        // channel 1 rises while masked: pending only
        pins(8'h02);
        wack(40);
        chk({7'h00, cap.valid}, 8'h00);
        rc(OFS_PEND, 8'h02, 8'h02);
        // channel 0 rises unmasked, after a write so no abort
        @(posedge clock_in);
        wdone <= 1'b1;
        pins(8'h03);
        wack(40);
        chk({cap.valid, cap.top, cap.channel, cap.priority_level}, 8'h80);
        chk({7'h00, ab_cap}, 8'h00);
        lat(d0);
        rc(OFS_PEND, 8'h01, 8'h00);
        rc(OFS_CENTRAL, 8'h10, 8'h00);
        repeat (20) @(posedge clock_in);
        rc(OFS_CENTRAL, 8'h10, 8'h10);
        // same again in nested mode with stack, segment push and wait mode, write pending so abort, slow return
        wr(OFS_CENTRAL, 8'h9F);
        stk <= 1'b1;
        seg <= 1'b1;
        wt <= 1'b1;
        wdone <= 1'b0;
        hold <= 8'h30;
        pins(8'h02);
        pins(8'h03);
        wack(80);
        chk({cap.valid, cap.top, cap.channel, cap.priority_level}, 8'h80);
        chk({7'h00, ab_cap}, 8'h01);
        lat(d1);
        chk(8'(d1 - d0), 8'h05);
        rc(OFS_CENTRAL, 8'h0F, 8'h08);
        repeat (70) @(posedge clock_in);
        rc(OFS_CENTRAL, 8'h1F, 8'h1F);
        // top level from a falling pin edge, maskable path
        wr(OFS_CENTRAL, 8'hB7);
        nmi <= 1'b0;
        wack(40);
        chk({cap.top, cap.vector}, {1'b1, TOP_VECTOR});
        lat(d0);
        rc(OFS_CENTRAL, 8'h50, 8'h10);
        chk({7'h00, busy}, 8'h01);
        repeat (60) @(posedge clock_in);
        rc(OFS_CENTRAL, 8'h10, 8'h10);
        // top mask cleared: pending but no grant until the lock is set
        wr(OFS_CENTRAL, 8'h97);
        nmi <= 1'b1;
        repeat (4) @(posedge clock_in);
        nmi <= 1'b0;
        top_exp(1'b0);
        rc(OFS_CENTRAL, 8'h40, 8'h40);
        core_op(1'b0, 1'b1);
        wr(OFS_LOCK, 8'h80);
        top_exp(1'b1);
        wr(OFS_LOCK, 8'h00);
        rc(OFS_LOCK, 8'h80, 8'h80);
        // watchdog as source: pin edges ignored
        wr(OFS_TOPCFG, 8'h00);
        nmi <= 1'b1;
        repeat (4) @(posedge clock_in);
        nmi <= 1'b0;
        top_exp(1'b0);
        @(posedge clock_in);
        wdog <= 1'b1;
        repeat (4) @(posedge clock_in);
        wdog <= 1'b0;
        top_exp(1'b1);
        // pin source with rising edge, then a software request
        wr(OFS_TOPCFG, 8'h0C);
        nmi <= 1'b1;
        top_exp(1'b1);
        wr(OFS_CENTRAL, 8'hC7);
        top_exp(1'b1);
        conclude();
    end
endmodule
bind tlic_top tlic_assertions #(.NUM_CH(NUM_CH)) u_tlic_assertions (.clock_in(clock_in),
    .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out), .write_done_in(write_done_in),
    .ack_out(ack_out), .abort_out(abort_out), .routine_start_out(routine_start_out),
    .top_busy_out(top_busy_out), .dma_block_out(dma_block_out));
`default_nettype wire
